//--- gppc_pkg.sv
/*
 gppc_pkg: constants and types shared by the port pad controller files.
 Assumes a 32-bit Avalon-MM register window with byte addresses.
*/
package gppc_pkg;

   // pins per port
   localparam int PINS = 8;
   // log2 of the byte stride between port register blocks
   localparam int PORT_SHIFT = 6;
   // bits per pin in the fabric route select field
   localparam int FAB_SEL_W = 3;

   // pad drive settings, code order is the pad encoding
   typedef enum logic [2:0] {
      DM_ANALOG,
      DM_INPUT,
      DM_WEAKUP_STRONGDN,
      DM_STRONGUP_WEAKDN,
      DM_OD_LOW,
      DM_OD_HIGH,
      DM_STRONG,
      DM_WEAK
   } gppc_drive_type;

   // pin output source select
   typedef enum logic [1:0] {
      SRC_DATA,
      SRC_FIXED,
      SRC_FABRIC,
      SRC_SPARE
   } gppc_src_type;

   // per-port register byte offsets
   localparam logic [5:0] OFS_DATA_OUT = 6'h00;
   localparam logic [5:0] OFS_PIN_STATE = 6'h04;
   localparam logic [5:0] OFS_DRIVE = 6'h08;
   localparam logic [5:0] OFS_BUF_CTL = 6'h0C;
   localparam logic [5:0] OFS_PIN_SEL = 6'h10;
   localparam logic [5:0] OFS_FAB_SEL = 6'h14;
   localparam logic [5:0] OFS_INT_CFG = 6'h18;
   localparam logic [5:0] OFS_INT_STAT = 6'h1C;
   localparam logic [5:0] OFS_INT_MASK = 6'h20;

   // global block, placed at port slot GLOBAL_SLOT
   localparam logic [2:0] GLOBAL_SLOT = 3'h7;
   localparam logic [5:0] OFS_IRQ_SUMMARY = 6'h00;
   localparam logic [5:0] OFS_HOLD_STAT = 6'h04;

   // buffer control field positions
   localparam int BUF_IN_LSB = 0;
   localparam int BUF_OUT_LSB = 8;
   localparam int BUF_SLEW_LSB = 16;
   localparam int BUF_THR_LSB = 24;

   // interrupt config: two bits per pin
   localparam int EDGE_RISE_BIT = 0;
   localparam int EDGE_FALL_BIT = 1;

   // threshold and slew encodings
   localparam logic THR_CMOS = 1'b0;
   localparam logic THR_LVTTL = 1'b1;
   localparam logic SLEW_FAST = 1'b0;
   localparam logic SLEW_SLOW = 1'b1;

   // reset values: every pad disabled
   localparam logic [7:0] RST_DATA_OUT = 8'h00;
   localparam logic [23:0] RST_DRIVE = 24'h000000;
   localparam logic [31:0] RST_BUF_CTL = 32'h00000000;
   localparam logic [15:0] RST_PIN_SEL = 16'h0000;
   localparam logic [23:0] RST_FAB_SEL = 24'h000000;
   localparam logic [15:0] RST_INT_CFG = 16'h0000;
   localparam logic [7:0] RST_INT_STAT = 8'h00;
   localparam logic [7:0] RST_INT_MASK = 8'h00;

endpackage : gppc_pkg

//--- gppc_pad_if.sv
/*
 gppc_pad_if: configuration of one pin from the port logic to its pad cell.
 Assumes the port logic drives ctl signals every cycle.
*/
`timescale 1ns/100ps
`default_nettype none

interface gppc_pad_if;
   gppc_pkg::gppc_drive_type drive;
   logic data;
   logic out_en;
   logic in_en;
   logic slew;
   logic thr;
   logic hold;
   logic in_buf_en;

   modport ctl (
      output drive, data, out_en, in_en, slew, thr, hold,
      input in_buf_en
   );
   modport pad (
      input drive, data, out_en, in_en, slew, thr, hold,
      output in_buf_en
   );
endinterface : gppc_pad_if

`default_nettype wire

//--- gppc_pad_cell.sv
/*
 gppc_pad_cell: per-pin hold latch and drive-mode decode for one pad.
 Assumes rst_n_i is the synchronised reset copy, asserted asynchronously.
*/
`timescale 1ns/100ps
`default_nettype none

module gppc_pad_cell (
   input wire logic clk_i,
   input wire logic rst_n_i,
   gppc_pad_if.pad cfg,
   output logic pad_o,
   output logic pad_oe_n_o,
   output logic pull_up_o,
   output logic pull_dn_o,
   output logic slew_o,
   output logic thr_o,
   output logic in_buf_en_o
);

   gppc_pkg::gppc_drive_type held_mode;
   logic held_data;
   logic held_oe;
   logic held_ie;
   logic held_slew;
   logic held_thr;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         held_mode <= gppc_pkg::DM_ANALOG;
         held_data <= 1'b0;
         held_oe <= 1'b0;
         held_ie <= 1'b0;
         held_slew <= gppc_pkg::SLEW_FAST;
         held_thr <= gppc_pkg::THR_CMOS;
      end else if (!cfg.hold) begin
         held_mode <= cfg.drive;
         held_data <= cfg.data;
         held_oe <= cfg.out_en;
         held_ie <= cfg.in_en;
         held_slew <= cfg.slew;
         held_thr <= cfg.thr;
      end
   end

   wire logic is_analog = (held_mode == gppc_pkg::DM_ANALOG);
   wire logic out_ok = held_oe & ~is_analog & (held_mode != gppc_pkg::DM_INPUT);

   wire logic up_strong_mode = (held_mode == gppc_pkg::DM_STRONGUP_WEAKDN) |
                               (held_mode == gppc_pkg::DM_OD_HIGH) |
                               (held_mode == gppc_pkg::DM_STRONG);
   wire logic dn_strong_mode = (held_mode == gppc_pkg::DM_WEAKUP_STRONGDN) |
                               (held_mode == gppc_pkg::DM_OD_LOW) |
                               (held_mode == gppc_pkg::DM_STRONG);
   wire logic up_weak_mode = (held_mode == gppc_pkg::DM_WEAKUP_STRONGDN) |
                             (held_mode == gppc_pkg::DM_WEAK);
   wire logic dn_weak_mode = (held_mode == gppc_pkg::DM_STRONGUP_WEAKDN) |
                             (held_mode == gppc_pkg::DM_WEAK);

   wire logic drive_hi = out_ok & held_data & up_strong_mode;
   wire logic drive_lo = out_ok & ~held_data & dn_strong_mode;

   assign pad_o = held_data;
   assign pad_oe_n_o = ~(drive_hi | drive_lo);
   assign pull_up_o = out_ok & held_data & up_weak_mode;
   assign pull_dn_o = out_ok & ~held_data & dn_weak_mode;
   assign slew_o = held_slew;
   assign thr_o = held_thr;
   assign in_buf_en_o = held_ie & ~is_analog;
   assign cfg.in_buf_en = held_ie & ~is_analog;

endmodule : gppc_pad_cell

`default_nettype wire

//--- gppc_top.sv
/*
 gppc_top: general-purpose pin ports with Avalon-MM registers, pin mux,
 pad control, input synchronisers and per-port interrupt requests.
 Assumes pad inputs synchronous-capable, hold_i from the power controller.
*/
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
//
// Behaviour
// - pins grouped in eight-bit ports
// - eight drive settings per pin
// - analog setting disables both buffers
// - per-pin CMOS or LVTTL threshold
// - separate input and output buffer enables
// - hold keeps configuration and output state
// - per-pin slew select sent to pad
// - reset forces every pad disabled
// - mux picks data, peripheral or fabric
// - data-out register and pin-state register
// - edge-enabled pins raise events, others never
// - one request line per port
`timescale 1ns/100ps
`default_nettype none

module gppc_top #(
   parameter int NUM_PORTS = 5,
   parameter int LAST_PORT_PINS = 4,
   parameter int ADDR_W = 9
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic hold_i,
   input wire logic [NUM_PORTS*8-1:0] periph_out_i,
   input wire logic [(2**gppc_pkg::FAB_SEL_W)-1:0] fabric_out_i,
   output logic [NUM_PORTS*8-1:0] pin_in_o,
   input wire logic [NUM_PORTS*8-1:0] pad_i,
   output logic [NUM_PORTS*8-1:0] pad_o,
   output logic [NUM_PORTS*8-1:0] pad_oe_n_o,
   output logic [NUM_PORTS*8-1:0] pad_pull_up_o,
   output logic [NUM_PORTS*8-1:0] pad_pull_dn_o,
   output logic [NUM_PORTS*8-1:0] pad_slew_o,
   output logic [NUM_PORTS*8-1:0] pad_thr_o,
   output logic [NUM_PORTS*8-1:0] pad_in_en_o,
   output logic [NUM_PORTS-1:0] port_irq_o,
   output logic irq_o
);

   localparam int NPINS = NUM_PORTS * gppc_pkg::PINS;
   localparam int LIVE_PINS = NPINS - gppc_pkg::PINS + LAST_PORT_PINS;
   localparam int SLOT_W = ADDR_W - gppc_pkg::PORT_SHIFT;

   // reset release through two flops
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // bus slave: one wait cycle per access
   logic bus_ack;
   logic [31:0] rd_word [NUM_PORTS];

   wire logic bus_req = avs_read_i | avs_write_i;
   wire logic wr_commit = avs_write_i & bus_ack;
   wire logic rd_take = avs_read_i & ~bus_ack;
   wire logic [SLOT_W-1:0] slot = avs_address_i[ADDR_W-1:gppc_pkg::PORT_SHIFT];
   wire logic [5:0] reg_ofs = {avs_address_i[5:2], 2'b00};
   wire logic port_ok = (int'(slot) < NUM_PORTS);
   wire logic glob_ok = (slot == SLOT_W'(gppc_pkg::GLOBAL_SLOT));
   wire logic [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                                {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

   wire logic [31:0] glob_rd =
      (reg_ofs == gppc_pkg::OFS_IRQ_SUMMARY) ? 32'(port_irq_o) :
      (reg_ofs == gppc_pkg::OFS_HOLD_STAT) ? {31'h0, hold_i} : 32'h0;
   wire logic [31:0] rd_sel = port_ok ? rd_word[slot] :
                              glob_ok ? glob_rd : 32'h0;

   assign avs_waitrequest_o = bus_req & ~bus_ack;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         bus_ack <= 1'b0;
      end else begin
         bus_ack <= bus_req & ~bus_ack;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata_o <= 32'h0;
      end else if (rd_take) begin
         avs_readdata_o <= rd_sel;
      end
   end

   // byte-lane merge of write data into a register
   function automatic logic [31:0] merge(input logic [31:0] old_v);
      merge = (old_v & ~be_mask) | (avs_writedata_i & be_mask);
   endfunction : merge

   assign irq_o = |port_irq_o;

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [7:0] data_out;
      logic [23:0] drive;
      logic [31:0] buf_ctl;
      logic [15:0] pin_sel;
      logic [23:0] fab_sel;
      logic [15:0] int_cfg;
      logic [7:0] int_stat;
      logic [7:0] int_mask;
      logic [7:0] pin_state;
      logic [7:0] pin_evt;

      wire logic sel = wr_commit & port_ok & (int'(slot) == p);
      wire logic wr_data = sel & (reg_ofs == gppc_pkg::OFS_DATA_OUT);
      wire logic wr_drive = sel & (reg_ofs == gppc_pkg::OFS_DRIVE);
      wire logic wr_buf = sel & (reg_ofs == gppc_pkg::OFS_BUF_CTL);
      wire logic wr_psel = sel & (reg_ofs == gppc_pkg::OFS_PIN_SEL);
      wire logic wr_fsel = sel & (reg_ofs == gppc_pkg::OFS_FAB_SEL);
      wire logic wr_icfg = sel & (reg_ofs == gppc_pkg::OFS_INT_CFG);
      wire logic wr_mask = sel & (reg_ofs == gppc_pkg::OFS_INT_MASK);
      wire logic wr_stat = sel & (reg_ofs == gppc_pkg::OFS_INT_STAT) & avs_byteenable_i[0];
      wire logic [7:0] stat_clr = wr_stat ? avs_writedata_i[7:0] : 8'h00;
      // event set wins over a same-cycle clear
      wire logic [7:0] next_int_stat = pin_evt | (int_stat & ~stat_clr);

      always_ff @(posedge mclk_i or negedge rst_n) begin
         if (!rst_n) begin
            data_out <= gppc_pkg::RST_DATA_OUT;
            drive <= gppc_pkg::RST_DRIVE;
            buf_ctl <= gppc_pkg::RST_BUF_CTL;
            pin_sel <= gppc_pkg::RST_PIN_SEL;
            fab_sel <= gppc_pkg::RST_FAB_SEL;
            int_cfg <= gppc_pkg::RST_INT_CFG;
            int_mask <= gppc_pkg::RST_INT_MASK;
            int_stat <= gppc_pkg::RST_INT_STAT;
         end else begin
            if (wr_data) begin
               data_out <= 8'(merge(32'(data_out)));
            end
            if (wr_drive) begin
               drive <= 24'(merge(32'(drive)));
            end
            if (wr_buf) begin
               buf_ctl <= merge(buf_ctl);
            end
            if (wr_psel) begin
               pin_sel <= 16'(merge(32'(pin_sel)));
            end
            if (wr_fsel) begin
               fab_sel <= 24'(merge(32'(fab_sel)));
            end
            if (wr_icfg) begin
               int_cfg <= 16'(merge(32'(int_cfg)));
            end
            if (wr_mask) begin
               int_mask <= 8'(merge(32'(int_mask)));
            end
            int_stat <= next_int_stat;
         end
      end

      assign port_irq_o[p] = |(int_stat & int_mask);

      assign rd_word[p] =
         (reg_ofs == gppc_pkg::OFS_DATA_OUT) ? {24'h0, data_out} :
         (reg_ofs == gppc_pkg::OFS_PIN_STATE) ? {24'h0, pin_state} :
         (reg_ofs == gppc_pkg::OFS_DRIVE) ? {8'h0, drive} :
         (reg_ofs == gppc_pkg::OFS_BUF_CTL) ? buf_ctl :
         (reg_ofs == gppc_pkg::OFS_PIN_SEL) ? {16'h0, pin_sel} :
         (reg_ofs == gppc_pkg::OFS_FAB_SEL) ? {8'h0, fab_sel} :
         (reg_ofs == gppc_pkg::OFS_INT_CFG) ? {16'h0, int_cfg} :
         (reg_ofs == gppc_pkg::OFS_INT_STAT) ? {24'h0, int_stat} :
         (reg_ofs == gppc_pkg::OFS_INT_MASK) ? {24'h0, int_mask} : 32'h0;

      for (genvar b = 0; b < gppc_pkg::PINS; b++) begin : g_pin
         localparam int G = p * gppc_pkg::PINS + b;
         localparam logic LIVE = (G < LIVE_PINS);

         logic sync_a;
         logic sync_b;
         logic level_prev;

         gppc_pad_if pif();

         wire gppc_pkg::gppc_src_type src = gppc_pkg::gppc_src_type'(pin_sel[2*b +: 2]);
         wire logic [gppc_pkg::FAB_SEL_W-1:0] fab_idx =
            fab_sel[gppc_pkg::FAB_SEL_W*b +: gppc_pkg::FAB_SEL_W];

         assign pif.data = (src == gppc_pkg::SRC_FIXED) ? periph_out_i[G] :
                           (src == gppc_pkg::SRC_FABRIC) ? fabric_out_i[fab_idx] :
                           data_out[b];
         assign pif.drive = gppc_pkg::gppc_drive_type'(drive[3*b +: 3]);
         assign pif.out_en = buf_ctl[gppc_pkg::BUF_OUT_LSB + b] & LIVE;
         assign pif.in_en = buf_ctl[gppc_pkg::BUF_IN_LSB + b] & LIVE;
         assign pif.slew = buf_ctl[gppc_pkg::BUF_SLEW_LSB + b];
         assign pif.thr = buf_ctl[gppc_pkg::BUF_THR_LSB + b];
         assign pif.hold = hold_i;

         gppc_pad_cell u_pad (
            .clk_i(mclk_i),
            .rst_n_i(rst_n),
            .cfg(pif),
            .pad_o(pad_o[G]),
            .pad_oe_n_o(pad_oe_n_o[G]),
            .pull_up_o(pad_pull_up_o[G]),
            .pull_dn_o(pad_pull_dn_o[G]),
            .slew_o(pad_slew_o[G]),
            .thr_o(pad_thr_o[G]),
            .in_buf_en_o(pad_in_en_o[G])
         );

         always_ff @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
               sync_a <= 1'b0;
               sync_b <= 1'b0;
            end else begin
               sync_a <= pad_i[G];
               sync_b <= sync_a;
            end
         end

         // pin state, zero when input buffer off
         always_ff @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
               pin_state[b] <= 1'b0;
               level_prev <= 1'b0;
            end else begin
               pin_state[b] <= sync_b & pif.in_buf_en;
               level_prev <= pin_state[b];
            end
         end

         assign pin_evt[b] =
            (int_cfg[2*b + gppc_pkg::EDGE_RISE_BIT] & pin_state[b] & ~level_prev) |
            (int_cfg[2*b + gppc_pkg::EDGE_FALL_BIT] & ~pin_state[b] & level_prev);

         assign pin_in_o[G] = pin_state[b];
      end
   end

endmodule : gppc_top

`default_nettype wire

//--- gppc_board.sv
/*
 gppc_board: board side of every pin, resolves the wire level.
 Assumes the bench drives ext_en_i and ext_val_i after rising edges.
*/
`timescale 1ns/100ps
`default_nettype none

module gppc_board #(
   parameter int N = 40
) (
   input wire logic mclk_i,
   input wire logic [N-1:0] pad_i,
   input wire logic [N-1:0] oe_n_i,
   input wire logic [N-1:0] up_i,
   input wire logic [N-1:0] dn_i,
   input wire logic [N-1:0] ext_en_i,
   input wire logic [N-1:0] ext_val_i,
   output logic [N-1:0] level_o
);
   logic [N-1:0] drift = '0;
   // floating pins wander every cycle
   always @(posedge mclk_i) begin
      drift <= ~drift;
   end
   always_comb begin
      for (int k = 0; k < N; k++) begin
         if (!oe_n_i[k])
            level_o[k] = pad_i[k];
         else if (ext_en_i[k])
            level_o[k] = ext_val_i[k];
         else if (up_i[k] || dn_i[k])
            level_o[k] = up_i[k];
         else
            level_o[k] = drift[k];
      end
   end
endmodule : gppc_board

`default_nettype wire

//--- gppc_top_properties.sv
/*
 gppc_top_properties: port-level assertions for gppc_top.
 Assumes it is bound into gppc_top, clock mclk_i, raw reset rstn_i.
*/
`timescale 1ns/100ps
`default_nettype none

module gppc_top_properties #(
   parameter int NUM_PORTS = 5,
   parameter int LAST_PORT_PINS = 4
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire logic hold_i,
   input wire logic [NUM_PORTS*8-1:0] pad_i,
   input wire logic [NUM_PORTS*8-1:0] pin_in_o,
   input wire logic [NUM_PORTS*8-1:0] pad_o,
   input wire logic [NUM_PORTS*8-1:0] pad_oe_n_o,
   input wire logic [NUM_PORTS*8-1:0] pad_in_en_o,
   input wire logic [NUM_PORTS-1:0] port_irq_o,
   input wire logic irq_o
);
   localparam int TOP = NUM_PORTS*8-1;
   localparam int GONE = TOP-7+LAST_PORT_PINS;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   pads_off_reset_a: assert property (disable iff (1'b0)
      !rstn_i |-> &pad_oe_n_o && pad_in_en_o == '0) else $error("pad enabled in reset");
   one_wait_cycle_a: assert property (
      $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus answer not after one wait cycle");
   input_gate_a: assert property (
      (pin_in_o & ~$past(pad_in_en_o)) == '0)
      else $error("pin state high with input buffer off");
   sync_delay_a: assert property (
      (pin_in_o & ~$past(pin_in_o) & ~$past(pad_i, 3)) == '0)
      else $error("pin state rose without pad high three cycles before");
   irq_summary_a: assert property (irq_o == (|port_irq_o))
      else $error("irq output differs from port requests");
   hold_freeze_a: assert property (
      hold_i [*2] |=> $stable(pad_o) && $stable(pad_oe_n_o))
      else $error("pad changed while hold active");
   absent_pins_a: assert property (
      &pad_oe_n_o[TOP:GONE] && pad_in_en_o[TOP:GONE] == '0)
      else $error("absent pin enabled");
   irq_cause_a: assert property (
      $rose(irq_o) |-> $past(avs_write_i) || $past(pin_in_o) != $past(pin_in_o, 2))
      else $error("irq rose without pin change or write");

   cover property ($rose(irq_o));
   cover property (hold_i [*2]);
   cover property (avs_read_i && !avs_waitrequest_o);
endmodule : gppc_top_properties

bind gppc_top gppc_top_properties #(.NUM_PORTS(NUM_PORTS), .LAST_PORT_PINS(LAST_PORT_PINS))
   gppc_top_properties_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .hold_i(hold_i),
   .pad_i(pad_i), .pin_in_o(pin_in_o), .pad_o(pad_o), .pad_oe_n_o(pad_oe_n_o),
   .pad_in_en_o(pad_in_en_o), .port_irq_o(port_irq_o), .irq_o(irq_o));

`default_nettype wire

//--- gppc_top_tb.sv
/*
 gppc_top_tb: self-checking bench for gppc_top over Avalon-MM.
 Assumes gppc_board resolves the pins and the checker is bound.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module gppc_top_tb;
   localparam logic [7:0] OE_LO = 8'hAB;
   localparam logic [7:0] OE_HI = 8'h97;
   // weak pull per drive setting: up with data high, down with data low
   localparam logic [7:0] PU_HI = 8'h84;
   localparam logic [7:0] PD_LO = 8'h88;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b1;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [8:0] avs_address_i = 9'h000;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h00000000;
   logic hold_i = 1'b0;
   logic [39:0] periph_out_i = 40'h0000000000;
   logic [7:0] fabric_out_i = 8'h00;
   logic [39:0] ext_en = 40'h0000000000;
   logic [39:0] ext_val = 40'h0000000000;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic irq_o;
   logic [4:0] port_irq_o;
   logic [39:0] pin_in_o, pad_i, pad_o, pad_oe_n_o, pad_pull_up_o, pad_pull_dn_o;
   logic [39:0] pad_slew_o, pad_thr_o, pad_in_en_o;
   logic [31:0] exp_q[$];
   logic [31:0] exp_r;
   logic [31:0] d;
   logic [23:0] f;
   logic [7:0] rev;
   int fails = 0;
   int total_checks = 0;
   int seed = 32'hcb8aed71;

   gppc_top gppc_top_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .hold_i(hold_i), .periph_out_i(periph_out_i),
      .fabric_out_i(fabric_out_i), .pin_in_o(pin_in_o), .pad_i(pad_i), .pad_o(pad_o),
      .pad_oe_n_o(pad_oe_n_o), .pad_pull_up_o(pad_pull_up_o), .pad_pull_dn_o(pad_pull_dn_o),
      .pad_slew_o(pad_slew_o), .pad_thr_o(pad_thr_o), .pad_in_en_o(pad_in_en_o),
      .port_irq_o(port_irq_o), .irq_o(irq_o));
   gppc_board gppc_board_inst (.mclk_i(mclk_i), .pad_i(pad_o), .oe_n_i(pad_oe_n_o),
      .up_i(pad_pull_up_o), .dn_i(pad_pull_dn_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
      .level_o(pad_i));

   initial begin
      forever #20 mclk_i = ~mclk_i;
   end

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : tick

   // request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] v);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= v;
      do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge mclk_i);
   endtask : bus

   task automatic wr(input logic [2:0] p, input logic [5:0] o, input logic [31:0] v);
      bus(1'b1, {p, o}, v);
   endtask : wr

   task automatic rd(input logic [2:0] p, input logic [5:0] o, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, {p, o}, 32'h00000000);
   endtask : rd

   always @(posedge mclk_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0) begin
         exp_r = exp_q.pop_front();
         `CHK(avs_readdata_o, exp_r)
      end
   end

   initial begin
      #200000;
      fails++;
      final_report();
   end

   initial begin
      rstn_i <= 1'b0;
      tick(6);
      rstn_i <= 1'b1;
      periph_out_i <= 40'({$random(seed), $random(seed)});
      fabric_out_i <= 8'($random(seed));
      tick(3);
      rd(3'h0, gppc_pkg::OFS_BUF_CTL, 32'h00000000);
      rd(3'h5, 6'h00, 32'h00000000);
      rd(3'h0, 6'h3C, 32'h00000000);
      $display("test reset done");
      d = $random(seed);
      wr(3'h0, gppc_pkg::OFS_DRIVE, 32'h00DB6DB6);
      wr(3'h0, gppc_pkg::OFS_BUF_CTL, 32'h3CC3FFFF);
      wr(3'h0, gppc_pkg::OFS_DATA_OUT, {24'h000000, d[7:0]});
      tick(4);
      `CHK(pad_oe_n_o[7:0], 8'h00)
      `CHK(pad_o[7:0], d[7:0])
      `CHK(pad_slew_o[7:0], 8'hC3)
      `CHK(pad_thr_o[7:0], 8'h3C)
      rd(3'h0, gppc_pkg::OFS_PIN_STATE, {24'h000000, d[7:0]});
      `CHK(pin_in_o[7:0], d[7:0])
      avs_byteenable_i <= 4'hE;
      wr(3'h0, gppc_pkg::OFS_DATA_OUT, {24'h000000, ~d[7:0]});
      avs_byteenable_i <= 4'hF;
      rd(3'h0, gppc_pkg::OFS_DATA_OUT, {24'h000000, d[7:0]});
      wr(3'h0, gppc_pkg::OFS_BUF_CTL, 32'h0000FF00);
      tick(5);
      `CHK(pad_in_en_o[7:0], 8'h00)
      rd(3'h0, gppc_pkg::OFS_PIN_STATE, 32'h00000000);
      wr(3'h0, gppc_pkg::OFS_BUF_CTL, 32'h000000FF);
      tick(2);
      `CHK(pad_oe_n_o[7:0], 8'hFF)
      `CHK(pad_in_en_o[7:0], 8'hFF)
      wr(3'h0, gppc_pkg::OFS_BUF_CTL, 32'h0000FFFF);
      wr(3'h0, gppc_pkg::OFS_DRIVE, 32'h00000000);
      tick(2);
      `CHK(pad_oe_n_o[7:0], 8'hFF)
      `CHK(pad_in_en_o[7:0], 8'h00)
      for (int m = 0; m < 8; m++) begin
         for (int v = 0; v < 2; v++) begin
            wr(3'h0, gppc_pkg::OFS_DRIVE, 32'(m));
            wr(3'h0, gppc_pkg::OFS_DATA_OUT, 32'(v));
            tick(2);
            `CHK(pad_oe_n_o[0], (v == 1) ? OE_HI[m] : OE_LO[m])
            `CHK(pad_pull_up_o[0], (v == 1) ? PU_HI[m] : 1'b0)
            `CHK(pad_pull_dn_o[0], (v == 0) ? PD_LO[m] : 1'b0)
         end
      end
      wr(3'h4, gppc_pkg::OFS_DRIVE, 32'h00DB6DB6);
      wr(3'h4, gppc_pkg::OFS_BUF_CTL, 32'h0000FFFF);
      tick(2);
      `CHK(pad_oe_n_o[39:32], 8'hF0)
      `CHK(pad_in_en_o[39:32], 8'h0F)
      $display("test drive modes done");
      wr(3'h0, gppc_pkg::OFS_DRIVE, 32'h00DB6DB6);
      wr(3'h0, gppc_pkg::OFS_PIN_SEL, 32'h00005555);
      tick(2);
      `CHK(pad_o[7:0], periph_out_i[7:0])
      for (int b = 0; b < 8; b++) begin
         f[3*b +: 3] = 3'(7 - b);
         rev[b] = fabric_out_i[7 - b];
      end
      wr(3'h0, gppc_pkg::OFS_FAB_SEL, {8'h00, f});
      wr(3'h0, gppc_pkg::OFS_PIN_SEL, 32'h0000AAAA);
      tick(2);
      `CHK(pad_o[7:0], rev)
      wr(3'h0, gppc_pkg::OFS_PIN_SEL, 32'h00000000);
      wr(3'h0, gppc_pkg::OFS_DATA_OUT, 32'h0000005A);
      tick(1);
      hold_i <= 1'b1;
      tick(2);
      wr(3'h0, gppc_pkg::OFS_DATA_OUT, 32'h000000A5);
      wr(3'h0, gppc_pkg::OFS_DRIVE, 32'h00000000);
      tick(2);
      `CHK(pad_o[7:0], 8'h5A)
      `CHK(pad_oe_n_o[7:0], 8'h00)
      rd(gppc_pkg::GLOBAL_SLOT, gppc_pkg::OFS_HOLD_STAT, 32'h00000001);
      hold_i <= 1'b0;
      tick(3);
      `CHK(pad_oe_n_o[7:0], 8'hFF)
      $display("test mux and hold done");
      ext_en[15:8] <= 8'hFF;
      wr(3'h1, gppc_pkg::OFS_DRIVE, 32'h00249249);
      wr(3'h1, gppc_pkg::OFS_INT_CFG, 32'h00000009);
      wr(3'h1, gppc_pkg::OFS_INT_MASK, 32'h00000001);
      wr(3'h1, gppc_pkg::OFS_BUF_CTL, 32'h000000FF);
      ext_val[9:8] <= 2'b11;
      tick(6);
      rd(3'h1, gppc_pkg::OFS_INT_STAT, 32'h00000001);
      `CHK(pad_in_en_o[15:8], 8'hFF)
      `CHK(port_irq_o, 5'h02)
      rd(gppc_pkg::GLOBAL_SLOT, gppc_pkg::OFS_IRQ_SUMMARY, 32'h00000002);
      wr(3'h1, gppc_pkg::OFS_INT_STAT, 32'h00000001);
      tick(1);
      `CHK(irq_o, 1'b0)
      ext_val[9:8] <= 2'b00;
      tick(6);
      rd(3'h1, gppc_pkg::OFS_INT_STAT, 32'h00000002);
      `CHK(port_irq_o, 5'h00)
      wr(3'h1, gppc_pkg::OFS_INT_MASK, 32'h00000002);
      tick(1);
      `CHK(irq_o, 1'b1)
      $display("test interrupts done");
      final_report();
   end
endmodule : gppc_top_tb

`default_nettype wire
